// >>> cpu_status_flag_register_test.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_status_flag_register_test;
  logic i_clk = 0, i_rst = 1;
  logic [4:0] v, ev = 0;
  logic [5:0] u = 0, alu;
  logic [7:0] e = 0, st, rd;
  logic bk;
  logic [16:0] p, q[$];
  logic [15:0] f, fw = 0;
  logic [31:0] r = 32'hbf27;
  int errors, checked;
  function logic [31:0] nx(logic [31:0] x); return {x[30:0], x[31]^x[21]^x[1]^x[0]}; endfunction
  task chk(logic [7:0] x, y); checked++;
    if (x !== y) begin errors++; $display("BAD %0t %h %h", $time, x, y); end endtask
  task stop_test; $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish; endtask
  csf_core_model i_core (.i_a(u), .o_alu(alu));
  csf_status_reg i_dut (.i_clk, .i_rst, .i_fwrite(fw), .i_alu(alu), .i_evt(ev),
    .i_rd_addr(fw[14:8]), .o_rd_data(rd), .o_status(st), .o_data_bank_select(bk));
  initial forever #10 i_clk = ~i_clk;
  always @(negedge i_clk) if (q.size() > 1) begin
    p = q.pop_front();
    chk(st, p[7:0]);
    chk(rd, p[15:8]);
    chk({7'h00, bk}, {7'h00, p[16]});
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 0;
    @(negedge i_clk) chk(st, 8'h00);
    repeat (400) begin
      @(posedge i_clk) r = nx(r);
      f = {r[0], r[1] ? 7'h03 : r[7:1], r[15:8]};
      v = r[20:16] & r[25:21] & r[30:26];
      fw <= f; ev <= v; u <= r[31:26];
      if (f[15:8] == 8'h83) e = {f[7:5], e[4:3], f[2:0]};
      for (int i = 0; i < 3; i++) if (r[31 - i]) e[2 - i] = r[28 - i];
      if (v[1:0]) e[4:3] = {1'b0, v[0]};
      if (v[2]) e[4] = 1;
      if (v[4:3]) e[4:3] = 0;
      q.push_back({e[5], (f[14:8] == 7'h03) ? e : 8'h00, e});
    end
    $display("random run done");
    stop_test;
  end
endmodule // cpu_status_flag_register_test
`default_nettype wire

// >>> csf_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module csf_core_model (input wire logic [5:0] i_a, output var csf_pkg::csf_alu_t o_alu);
  assign o_alu = i_a;
endmodule // csf_core_model
`default_nettype wire

// >>> csf_pkg.sv
package csf_pkg;
  localparam logic [6:0] CSF_STATUS_ADDR   = 7'h03;
  localparam logic [7:0] CSF_STATUS_RESET  = 8'h00;
  localparam logic [7:0] CSF_RD_IDLE       = 8'h00;
  localparam int         CSF_BIT_CARRY     = 0;
  localparam int         CSF_BIT_HALFCARRY = 1;
  localparam int         CSF_BIT_ZERO      = 2;
  localparam int         CSF_BIT_POWERDOWN = 3;
  localparam int         CSF_BIT_WDT       = 4;
  localparam int         CSF_BIT_BANK      = 5;
  localparam int         CSF_BIT_SPARE_LO  = 6;
  localparam int         CSF_BIT_SPARE_HI  = 7;

  // file-register write from the core
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } csf_fwrite_t;

  // alu flag update request
  typedef struct packed {
    logic upd_z;
    logic upd_dc;
    logic upd_c;
    logic z;
    logic dc;
    logic c;
  } csf_alu_t;

  // reset-cause and instruction events
  typedef struct packed {
    logic por;
    logic low_voltage_reset;
    logic wdt_timeout;
    logic watchdog_clear_instr;
    logic sleep_instr;
  } csf_evt_t;
endpackage

// >>> csf_props.sv
`timescale 1ns/100ps
`default_nettype none
module csf_props import csf_pkg::*; (input wire logic i_clk, i_rst, input wire logic [6:0] i_rd_addr,
  input wire csf_fwrite_t i_fwrite, input wire csf_alu_t i_alu, input wire csf_evt_t i_evt,
  input wire logic [7:0] o_rd_data, o_status, input wire logic o_data_bank_select);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_bank_out: assert property (o_data_bank_select == o_status[5]) else $error("bank");
  a_wdt_set: assert property (i_evt.wdt_timeout & !i_evt.por & !i_evt.low_voltage_reset
    |=> o_status[4]) else $error("wdt");
  a_cause_clr: assert property (i_evt.por | i_evt.low_voltage_reset |=> !o_status[4:3])
    else $error("cause");
  a_ro_hold: assert property (!i_evt |=> $stable(o_status[4:3])) else $error("ro");
  a_carry_alu: assert property (i_alu.upd_c |=> o_status[0] == $past(i_alu.c)) else $error("c");
  a_zero_alu: assert property (i_alu.upd_z |=> o_status[2] == $past(i_alu.z)) else $error("z");
  a_spare_wr: assert property (i_fwrite[15:8] == 8'h83 |=> o_status[7:5] == $past(i_fwrite[7:5]))
    else $error("wr");
  a_rd_port: assert property (##1 o_rd_data == ($past(i_rd_addr) == 7'h03 ? o_status : 8'h00))
    else $error("rd");
  cover property (i_evt.sleep_instr);
  cover property (i_alu.upd_c && i_fwrite.wr);
  cover property (o_data_bank_select);
endmodule // csf_props
bind csf_status_reg csf_props u_props (.*);
`default_nettype wire

// >>> csf_status_reg.sv
// What this block does
// - Status register sits at file-register address 03H.
// - Any instruction may write the status register; the write leaves bits 4 and 3 unchanged.
// - ALU-updated zero, half-carry, carry bits ignore the write; ALU outcome wins.
// - Bit 5 selects data RAM bank: 0 bank zero, 1 bank one.
// - Bit 4 set on watchdog timeout; cleared by POR, low-voltage reset, clear, sleep.
// - Bit 3 set by sleep; cleared by POR, low-voltage reset, watchdog-clear.
// - Bit 1 half carry: low-nibble carry on add, inverted borrow on subtract.
`timescale 1ns/100ps
`default_nettype none
module csf_status_reg (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire csf_pkg::csf_fwrite_t i_fwrite,
  input  wire csf_pkg::csf_alu_t  i_alu,
  input  wire csf_pkg::csf_evt_t  i_evt,
  input  wire logic [6:0]         i_rd_addr,
  output logic [7:0]              o_rd_data,
  output logic [7:0]              o_status,
  output logic                    o_data_bank_select
);
  import csf_pkg::*;

  // one register per status concern, next values built alongside
  logic [1:0] spare_q;
  logic [1:0] spare_d;
  logic       bank_q;
  logic       bank_d;
  logic       timeout_q;
  logic       timeout_d;
  logic       powerdown_q;
  logic       powerdown_d;
  logic       zero_q;
  logic       zero_d;
  logic       half_carry_q;
  logic       half_carry_d;
  logic       carry_q;
  logic       carry_d;
  logic [7:0] status_d;
  logic       wr_hit;
  logic       rd_hit;
  logic       cause_clr;

  // file-register write and read decode
  assign wr_hit = i_fwrite.wr && (i_fwrite.addr == CSF_STATUS_ADDR);
  assign rd_hit = (i_rd_addr == CSF_STATUS_ADDR);
  // power-on and low-voltage resets clear both reset-cause flags
  assign cause_clr = i_evt.por || i_evt.low_voltage_reset;

  // general-purpose bits, one slice per bit
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_spare
      always_comb begin
        spare_d[g] = spare_q[g];
        if (wr_hit) begin
          spare_d[g] = i_fwrite.data[CSF_BIT_SPARE_LO + g];
        end
      end

      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          spare_q[g] <= CSF_STATUS_RESET[CSF_BIT_SPARE_LO + g];
        end else begin
          spare_q[g] <= spare_d[g];
        end
      end
    end
  endgenerate

  // data ram bank select, plain read/write bit
  always_comb begin
    bank_d = bank_q;
    if (wr_hit) begin
      bank_d = i_fwrite.data[CSF_BIT_BANK];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bank_q <= CSF_STATUS_RESET[CSF_BIT_BANK];
    end else begin
      bank_q <= bank_d;
    end
  end

  // timeout flag: read-only, timeout set beats the clear instructions
  always_comb begin
    timeout_d = timeout_q;
    if (i_evt.watchdog_clear_instr || i_evt.sleep_instr) begin
      timeout_d = 1'b0;
    end
    if (i_evt.wdt_timeout) begin
      timeout_d = 1'b1;
    end
    if (cause_clr) begin
      timeout_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      timeout_q <= CSF_STATUS_RESET[CSF_BIT_WDT];
    end else begin
      timeout_q <= timeout_d;
    end
  end

  // power-down flag: read-only, sleep set beats the clear instruction
  always_comb begin
    powerdown_d = powerdown_q;
    if (i_evt.watchdog_clear_instr) begin
      powerdown_d = 1'b0;
    end
    if (i_evt.sleep_instr) begin
      powerdown_d = 1'b1;
    end
    if (cause_clr) begin
      powerdown_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      powerdown_q <= CSF_STATUS_RESET[CSF_BIT_POWERDOWN];
    end else begin
      powerdown_q <= powerdown_d;
    end
  end

  // zero flag: alu result overrides a file write in the same cycle
  always_comb begin
    zero_d = zero_q;
    if (wr_hit) begin
      zero_d = i_fwrite.data[CSF_BIT_ZERO];
    end
    if (i_alu.upd_z) begin
      zero_d = i_alu.z;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      zero_q <= CSF_STATUS_RESET[CSF_BIT_ZERO];
    end else begin
      zero_q <= zero_d;
    end
  end

  // half-carry flag, already in inverted-borrow sense for subtraction
  always_comb begin
    half_carry_d = half_carry_q;
    if (wr_hit) begin
      half_carry_d = i_fwrite.data[CSF_BIT_HALFCARRY];
    end
    if (i_alu.upd_dc) begin
      half_carry_d = i_alu.dc;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      half_carry_q <= CSF_STATUS_RESET[CSF_BIT_HALFCARRY];
    end else begin
      half_carry_q <= half_carry_d;
    end
  end

  // carry flag, already in inverted-borrow sense for subtraction
  always_comb begin
    carry_d = carry_q;
    if (wr_hit) begin
      carry_d = i_fwrite.data[CSF_BIT_CARRY];
    end
    if (i_alu.upd_c) begin
      carry_d = i_alu.c;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      carry_q <= CSF_STATUS_RESET[CSF_BIT_CARRY];
    end else begin
      carry_q <= carry_d;
    end
  end

  // next status byte, also feeds the write-through read port
  always_comb begin
    status_d                    = CSF_STATUS_RESET;
    status_d[CSF_BIT_SPARE_HI]  = spare_d[1];
    status_d[CSF_BIT_SPARE_LO]  = spare_d[0];
    status_d[CSF_BIT_BANK]      = bank_d;
    status_d[CSF_BIT_WDT]       = timeout_d;
    status_d[CSF_BIT_POWERDOWN] = powerdown_d;
    status_d[CSF_BIT_ZERO]      = zero_d;
    status_d[CSF_BIT_HALFCARRY] = half_carry_d;
    status_d[CSF_BIT_CARRY]     = carry_d;
  end

  // outputs come straight from flops
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_status <= CSF_STATUS_RESET;
    end else begin
      o_status <= status_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data_bank_select <= CSF_STATUS_RESET[CSF_BIT_BANK];
    end else begin
      o_data_bank_select <= bank_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= CSF_RD_IDLE;
    end else begin
      o_rd_data <= rd_hit ? status_d : CSF_RD_IDLE;
    end
  end
endmodule // csf_status_reg
`default_nettype wire
